// ===== src/tmwd_regs.vh
// Register map, field positions and constants of the timer/watchdog
`ifndef TMWD_REGS_VH
`define TMWD_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define TMWD_OFS_CNT_HI    8'hF8
`define TMWD_OFS_CNT_LO    8'hF9
`define TMWD_OFS_PRESC     8'hFA
`define TMWD_OFS_TCTRL     8'hFB
`define TMWD_OFS_WCTRL     8'hFC

// ****************************************
// Reset values
// ****************************************
`define TMWD_RST_CNT_HI    8'hFF
`define TMWD_RST_CNT_LO    8'hFF
`define TMWD_RST_PRESC     8'hFF
`define TMWD_RST_TCTRL     8'h12
`define TMWD_RST_WCTRL     8'h7F

// ****************************************
// Timer control fields
// ****************************************
`define TMWD_TC_RUN        7
`define TMWD_TC_SINGLE     6
`define TMWD_TC_INMD_HI    5
`define TMWD_TC_INMD_LO    4
`define TMWD_TC_INPUT_GATE_ENABLE       3
`define TMWD_TC_OUTPUT_MODE_SELECT      2
`define TMWD_TC_PWMLVL     1
`define TMWD_TC_OUTPUT_ENABLE_BIT      0

// Wait control: watchdog enable, active low
`define TMWD_WC_WATCHDOG_ENABLE_N_N    6

// Input modes {input_mode_hi, input_mode_lo}
`define TMWD_IM_EVENT      2'h0
`define TMWD_IM_GATED      2'h1
`define TMWD_IM_TRIG       2'h2
`define TMWD_IM_RETRIG     2'h3

// ****************************************
// Watchdog and timing constants
// ****************************************
`define TMWD_REFRESH_ARM   8'hAA
`define TMWD_REFRESH_FIRE  8'h55
`define TMWD_HW_CONST      16'hFFFF
`define TMWD_CLK_DIV       2'h3
`define TMWD_RD_IDLE       8'h00

`endif

// ===== src/tmwd_presc.v
// 8-bit prescaler: divides incoming steps by reload value plus one
module tmwd_presc (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       srst,
    // Control
    input  wire       restart,
    input  wire       step_in,
    input  wire [7:0] presc_val,
    // Output step
    output reg        step_out
);

    reg [7:0] pcnt_ff;

    // Up-count steps; compare with current value, so changes act at once
    always @(posedge clk_sys) begin
        if (srst || restart) begin
            pcnt_ff  <= 8'h00;
            step_out <= 1'b0;
        end else if (step_in) begin
            if (pcnt_ff >= presc_val) begin
                pcnt_ff  <= 8'h00;
                step_out <= 1'b1;
            end else begin
                pcnt_ff  <= pcnt_ff + 8'h01;
                step_out <= 1'b0;
            end
        end else begin
            step_out <= 1'b0;
        end
    end

endmodule // tmwd_presc

// ===== src/tmwd_core.v
// Timer/watchdog: counter, output pin, watchdog and interrupt routing
`include "tmwd_regs.vh"

module tmwd_core (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       srst,
    input  wire       rst_is_external,
    // Register file port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // Pins
    input  wire       hw_watchdog_strap,
    input  wire       external_count_input,
    input  wire       ext_channel_a0,
    input  wire       nmi_pin,
    output reg        timer_output_pin,
    // Interrupt selectors
    input  wire       chan_a0_source_sel,
    input  wire       top_level_source_sel,
    // Requests
    output reg        chan_a0_req,
    output reg        top_level_req,
    output reg        sys_reset_req,
    output reg        watchdog_reset_flag
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [3:0] sync1_ff;
    reg [3:0] sync2_ff;
    reg       cin_prev_ff;

    // Two stages per pin, nothing reads the first stage
    always @(posedge clk_sys) begin
        sync1_ff <= {nmi_pin, ext_channel_a0, external_count_input,
                     hw_watchdog_strap};
        sync2_ff <= sync1_ff;
    end

    wire strap_s = sync2_ff[0];
    wire cin_s   = sync2_ff[1];
    wire a0_s    = sync2_ff[2];
    wire nmi_s   = sync2_ff[3];

    // ****************************************
    // Registers
    // ****************************************
    reg [15:0] count_ff;
    reg [15:0] const_ff;
    reg        const_new_ff;
    reg [7:0]  presc_ff;
    reg [7:0]  tctrl_ff;
    reg [7:0]  wctrl_ff;
    reg        hw_wdg_ff;
    reg        cap_pend_ff;
    reg        armed_ff;
    reg        trig_ok_ff;
    reg [1:0]  div_ff;
    reg        tick_ff;
    reg        wdg_prev_ff;

    wire wr_hi  = reg_wr && (reg_addr == `TMWD_OFS_CNT_HI);
    wire wr_lo  = reg_wr && (reg_addr == `TMWD_OFS_CNT_LO);
    wire wr_pr  = reg_wr && (reg_addr == `TMWD_OFS_PRESC);
    wire wr_tc  = reg_wr && (reg_addr == `TMWD_OFS_TCTRL);
    wire wr_wc  = reg_wr && (reg_addr == `TMWD_OFS_WCTRL);

    // Watchdog mode from strap capture or the software bit
    wire wdg_mode = hw_wdg_ff || !wctrl_ff[`TMWD_WC_WATCHDOG_ENABLE_N_N];
    wire run      = tctrl_ff[`TMWD_TC_RUN];
    wire input_gate_enable     = tctrl_ff[`TMWD_TC_INPUT_GATE_ENABLE];
    wire [1:0] imode = {tctrl_ff[`TMWD_TC_INMD_HI], tctrl_ff[`TMWD_TC_INMD_LO]};

    // Falling edge of the count input
    wire cin_fall = cin_prev_ff && !cin_s;

    // Refresh completes on 55h right after an armed AAh
    wire refresh = wr_lo && armed_ff && (reg_wdata == `TMWD_REFRESH_FIRE);

    // ****************************************
    // Counting enable and step source
    // ****************************************
    reg count_on;
    reg step_src;

    // Watchdog overrides run, single and input selections
    always @* begin
        count_on = 1'b0;
        step_src = tick_ff;
        if (wdg_mode) begin
            count_on = 1'b1;
            step_src = tick_ff;
        end else if (run) begin
            if (!input_gate_enable) begin
                count_on = 1'b1;
            end else begin
                case (imode)
                    `TMWD_IM_EVENT: begin
                        count_on = 1'b1;
                        step_src = cin_fall;
                    end
                    `TMWD_IM_GATED: begin
                        count_on = cin_s;
                    end
                    `TMWD_IM_TRIG: begin
                        count_on = trig_ok_ff;
                    end
                    `TMWD_IM_RETRIG: begin
                        count_on = 1'b1;
                    end
                    default: begin
                        count_on = 1'b0;
                    end
                endcase
            end
        end
    end

    // Retrigger restarts from the constant
    wire retrig = !wdg_mode && run && input_gate_enable && (imode == `TMWD_IM_RETRIG) && cin_fall;

    // ****************************************
    // Clock divider and prescaler
    // ****************************************
    wire step;

    // Internal clock divided by four
    always @(posedge clk_sys) begin
        if (srst) begin
            div_ff  <= 2'h0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= div_ff + 2'h1;
            tick_ff <= (div_ff == `TMWD_CLK_DIV);
        end
    end

    tmwd_presc u_presc (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .restart   (refresh || retrig),
        .step_in   (step_src && count_on),
        .presc_val (presc_ff),
        .step_out  (step)
    );

    // Terminal count: counter at zero when a step arrives
    wire eoc = step && (count_ff == 16'h0000);

    // ****************************************
    // Counter and constant
    // ****************************************
    wire [15:0] eff_const = hw_wdg_ff ? `TMWD_HW_CONST : const_ff;
    wire        wdg_entry = wdg_mode && !wdg_prev_ff;
    wire        start_new = wr_tc && reg_wdata[`TMWD_TC_RUN] && !run && const_new_ff;

    // Counter runs, reloads at terminal count or refresh
    always @(posedge clk_sys) begin
        if (srst) begin
            count_ff     <= {`TMWD_RST_CNT_HI, `TMWD_RST_CNT_LO};
            const_new_ff <= 1'b0;
        end else if (refresh || retrig || wdg_entry) begin
            count_ff     <= eff_const;
            const_new_ff <= 1'b0;
        end else if (eoc) begin
            count_ff     <= eff_const;
            const_new_ff <= 1'b0;
        end else if (start_new) begin
            count_ff     <= eff_const;
            const_new_ff <= 1'b0;
        end else begin
            if (step) begin
                count_ff <= count_ff - 16'h0001;
            end
            if ((wr_hi || wr_lo) && !wdg_mode) begin
                const_new_ff <= 1'b1;
            end
        end
    end

    // Constant writes are ignored in watchdog mode
    always @(posedge clk_sys) begin
        if (srst) begin
            const_ff <= {`TMWD_RST_CNT_HI, `TMWD_RST_CNT_LO};
        end else if (!wdg_mode) begin
            if (wr_hi) begin
                const_ff[15:8] <= reg_wdata;
            end
            if (wr_lo) begin
                const_ff[7:0] <= reg_wdata;
            end
        end
    end

    // ****************************************
    // Refresh sequence
    // ****************************************
    // AAh on the low byte arms; any other write clears the arm
    always @(posedge clk_sys) begin
        if (srst) begin
            armed_ff <= 1'b0;
        end else if (reg_wr) begin
            armed_ff <= wr_lo && (reg_wdata == `TMWD_REFRESH_ARM);
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // Prescaler is writable in every mode
    always @(posedge clk_sys) begin
        if (srst) begin
            presc_ff <= `TMWD_RST_PRESC;
        end else if (wr_pr) begin
            presc_ff <= reg_wdata;
        end
    end

    // Timer control; single mode clears run at terminal count
    always @(posedge clk_sys) begin
        if (srst) begin
            tctrl_ff <= `TMWD_RST_TCTRL;
        end else if (wr_tc) begin
            tctrl_ff <= reg_wdata;
        end else if (eoc && !wdg_mode && tctrl_ff[`TMWD_TC_SINGLE]) begin
            tctrl_ff[`TMWD_TC_RUN] <= 1'b0;
        end
    end

    // Enable bit can only be cleared by software
    always @(posedge clk_sys) begin
        if (srst) begin
            wctrl_ff <= `TMWD_RST_WCTRL;
        end else if (wr_wc) begin
            wctrl_ff <= {reg_wdata[7],
                         wctrl_ff[`TMWD_WC_WATCHDOG_ENABLE_N_N] & reg_wdata[`TMWD_WC_WATCHDOG_ENABLE_N_N],
                         reg_wdata[5:0]};
        end
    end

    // Trigger arm, edge history and mode history
    always @(posedge clk_sys) begin
        if (srst) begin
            trig_ok_ff  <= 1'b0;
            cin_prev_ff <= 1'b1;
            wdg_prev_ff <= 1'b0;
        end else begin
            cin_prev_ff <= cin_s;
            wdg_prev_ff <= wdg_mode;
            if (!run) begin
                trig_ok_ff <= 1'b0;
            end else if (cin_fall) begin
                trig_ok_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // Hardware watchdog strap capture
    // ****************************************
    // External reset reopens capture; other resets keep the state
    always @(posedge clk_sys) begin
        if (srst) begin
            if (rst_is_external) begin
                hw_wdg_ff   <= 1'b0;
                cap_pend_ff <= 1'b1;
            end
        end else if (cap_pend_ff) begin
            hw_wdg_ff   <= !strap_s;
            cap_pend_ff <= 1'b0;
        end
    end

    // ****************************************
    // Output pin
    // ****************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            timer_output_pin <= 1'b1;
        end else if (!tctrl_ff[`TMWD_TC_OUTPUT_ENABLE_BIT]) begin
            timer_output_pin <= 1'b1;
        end else if (eoc) begin
            if (tctrl_ff[`TMWD_TC_OUTPUT_MODE_SELECT]) begin
                timer_output_pin <= tctrl_ff[`TMWD_TC_PWMLVL];
            end else begin
                timer_output_pin <= !timer_output_pin;
            end
        end
    end

    // ****************************************
    // Interrupt routing and reset request
    // ****************************************
    wire tmr_evt = eoc && !wdg_mode;

    always @(posedge clk_sys) begin
        if (srst) begin
            chan_a0_req   <= 1'b0;
            top_level_req <= 1'b0;
            sys_reset_req <= 1'b0;
        end else begin
            chan_a0_req   <= chan_a0_source_sel ? a0_s : tmr_evt;
            top_level_req <= top_level_source_sel ? nmi_s :
                             (tmr_evt && chan_a0_source_sel);
            sys_reset_req <= eoc && wdg_mode;
        end
    end

    // Flag set by the watchdog request; kept across its reset, an external one clears it
    always @(posedge clk_sys) begin
        if (sys_reset_req) begin
            watchdog_reset_flag <= 1'b1;
        end else if (srst && rst_is_external) begin
            watchdog_reset_flag <= 1'b0;
        end
    end

    // ****************************************
    // Read data, one cycle after address
    // ****************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= `TMWD_RD_IDLE;
        end else begin
            case (reg_addr)
                `TMWD_OFS_CNT_HI: reg_rdata <= count_ff[15:8];
                `TMWD_OFS_CNT_LO: reg_rdata <= count_ff[7:0];
                `TMWD_OFS_PRESC:  reg_rdata <= presc_ff;
                `TMWD_OFS_TCTRL:  reg_rdata <= tctrl_ff;
                `TMWD_OFS_WCTRL:  reg_rdata <= wctrl_ff;
                default:          reg_rdata <= `TMWD_RD_IDLE;
            endcase
        end
    end

endmodule // tmwd_core

// ===== dv/tmwd_sys_model.sv
// Reset logic partner: turns reset causes into the core's synchronous reset
module tmwd_sys_model (
    // Clock
    input  wire logic clk_sys,
    // Reset causes
    input  wire logic ext_rst_req,
    input  wire logic sys_reset_req,
    // Reset to the core
    output wire logic srst,
    output wire logic rst_is_external
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] cnt_ff = 2'h2;
    logic       ext_ff = 1'b1;
    // Hold reset while a request lasts and two cycles after it ends, remembering its cause
    always @(posedge clk_sys) begin
        if (ext_rst_req || sys_reset_req) begin
            cnt_ff <= 2'h2;
            ext_ff <= ext_rst_req;
        end else if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1;
        end
    end
    assign srst            = (cnt_ff != 2'h0);
    assign rst_is_external = ext_ff;
endmodule // tmwd_sys_model

// ===== dv/tmwd_core_asserts.sv
// Port-level concurrent checks of the timer/watchdog core
module tmwd_core_asserts (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       rst_is_external,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Pins and selectors
    input wire logic       ext_channel_a0,
    input wire logic       nmi_pin,
    input wire logic       timer_output_pin,
    input wire logic       chan_a0_source_sel,
    input wire logic       top_level_source_sel,
    // Requests
    input wire logic       chan_a0_req,
    input wire logic       top_level_req,
    input wire logic       sys_reset_req,
    input wire logic       watchdog_reset_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       req_q_ff, srst_q_ff, wd_rst_ff;
    logic [2:0] fbw_ff;
    // Remember a reset caused by a watchdog request and recent control writes
    always @(posedge clk_sys) begin
        req_q_ff  <= sys_reset_req;
        srst_q_ff <= srst;
        wd_rst_ff <= srst & (wd_rst_ff | (req_q_ff & ~srst_q_ff & ~rst_is_external));
        fbw_ff    <= {fbw_ff[1:0], reg_wr && reg_addr == 8'hFB};
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ****************************************
    // Properties
    // ****************************************
    property p_rst_out;
        $fell(srst) |-> timer_output_pin && !chan_a0_req && !top_level_req && !sys_reset_req;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
    property p_unmapped;
        (reg_addr < 8'hF8 || reg_addr > 8'hFC) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_presc_rw;
        reg_wr && reg_addr == 8'hFA ##1 !reg_wr && reg_addr == 8'hFA
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_presc_rw: assert property (p_presc_rw) else $error("prescaler readback");
    property p_no_route;
        sys_reset_req && !$past(chan_a0_source_sel) |-> !chan_a0_req;
    endproperty
    a_no_route: assert property (p_no_route) else $error("watchdog event routed");
    property p_a0_pin;
        (chan_a0_source_sel && ext_channel_a0)[*5] |-> chan_a0_req;
    endproperty
    a_a0_pin: assert property (p_a0_pin) else $error("channel A0 misses pin");
    property p_top_nmi;
        (top_level_source_sel && !nmi_pin)[*5] |-> !top_level_req;
    endproperty
    a_top_nmi: assert property (p_top_nmi) else $error("top level not from pin");
    property p_both_tc;
        (!chan_a0_source_sel && !top_level_source_sel)[*3] |-> !top_level_req;
    endproperty
    a_both_tc: assert property (p_both_tc) else $error("top level fired with A0");
    property p_pin_evt;
        $changed(timer_output_pin) && !$past(chan_a0_source_sel) && fbw_ff == 3'h0
            |-> chan_a0_req || sys_reset_req;
    endproperty
    a_pin_evt: assert property (p_pin_evt) else $error("pin moved off end of count");
    property p_flag;
        $fell(srst) && wd_rst_ff |=> watchdog_reset_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("watchdog reset flag not set");
endmodule // tmwd_core_asserts

bind tmwd_core tmwd_core_asserts chk_u (
    .clk_sys(clk_sys), .srst(srst), .rst_is_external(rst_is_external),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ext_channel_a0(ext_channel_a0), .nmi_pin(nmi_pin), .timer_output_pin(timer_output_pin),
    .chan_a0_source_sel(chan_a0_source_sel), .top_level_source_sel(top_level_source_sel),
    .chan_a0_req(chan_a0_req), .top_level_req(top_level_req),
    .sys_reset_req(sys_reset_req), .watchdog_reset_flag(watchdog_reset_flag)
);

// ===== dv/tb.sv
// Self-checking bench of the timer/watchdog core
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
        $display("BAD %s exp %0h got %0h", nm, e, g); end end
    logic       clk_sys = 1'b0;
    logic       ext_rst_req = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       strap = 1'b1;
    logic       cnt_in = 1'b1;
    logic       ext_a0 = 1'b0;
    logic       nmi = 1'b0;
    logic       a0_sel = 1'b0;
    logic       top_sel = 1'b0;
    wire        srst, rst_is_ext, pin, a0_req, top_req, sys_req, wd_flag;
    wire  [7:0] reg_rdata;
    wire  [2:0] evs = {sys_req, top_req, a0_req};
    int         mismatches = 0, checks_done = 0, seed = 1, cyc = 0, n, t0, a0_seen;
    logic [7:0] v, c, p, q;
    logic [7:0] map [7] = '{8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hF7, 8'hFD};
    logic [7:0] rst_val [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h12, 8'h7F, 8'h00, 8'h00};

    tmwd_core dut_u (.clk_sys(clk_sys), .srst(srst), .rst_is_external(rst_is_ext),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .hw_watchdog_strap(strap), .external_count_input(cnt_in), .ext_channel_a0(ext_a0),
        .nmi_pin(nmi), .timer_output_pin(pin), .chan_a0_source_sel(a0_sel),
        .top_level_source_sel(top_sel), .chan_a0_req(a0_req), .top_level_req(top_req),
        .sys_reset_req(sys_req), .watchdog_reset_flag(wd_flag));
    tmwd_sys_model sys_u (.clk_sys(clk_sys), .ext_rst_req(ext_rst_req),
        .sys_reset_req(sys_req), .srst(srst), .rst_is_external(rst_is_ext));

    // Clock, cycle count and channel A0 event count
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    always @(negedge clk_sys) if (a0_req === 1'b1) a0_seen++;

    // ****************************************
    // Tasks
    // ****************************************
    function automatic int period(input logic [7:0] cv, input logic [7:0] pv);
        return (cv + 1) * (pv + 1) * 4;
    endfunction
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task refresh;
        @(posedge clk_sys);
        reg_addr  <= 8'hF9;
        reg_wdata <= 8'hAA;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wdata <= 8'h55;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task wait_ev(input int s, output int k);
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (evs[s] !== 1'b1 && k < 4000);
        if (k >= 4000) mismatches++;
    endtask
    task ext_reset(input logic s);
        @(posedge clk_sys);
        strap       <= s;
        ext_rst_req <= 1'b1;
        repeat (3) @(posedge clk_sys);
        ext_rst_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        ext_rst_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 7; i++) begin
            rd(map[i], v);
            `CHK("reset value", rst_val[i], v)
        end
        for (int m = 0; m < 4; m++) begin
            q = $random(seed);
            c = {2'b00, m[1:0], q[3:0]};
            wr(8'hFB, c);
            rd(8'hFB, v);
            `CHK("control", c, v)
        end
        for (int i = 0; i < 3; i++) begin
            q = $random(seed);
            c = {4'h0, q[3:0]};
            p = {6'h00, q[5:4]};
            wr(8'hF8, 8'h00);
            wr(8'hF9, c);
            wr(8'hFA, p);
            wr(8'hFB, 8'h81);
            wait_ev(0, n);
            v[0] = pin;
            wait_ev(0, n);
            `CHK("period", period(c, p), n)
            `CHK("square", ~v[0], pin)
            rd(8'hF9, v);
            `CHK("live count", 1'b1, v <= c)
            wr(8'hFB, 8'h00);
        end
        wr(8'hF9, 8'h0F);
        wr(8'hFA, 8'h01);
        wr(8'hFB, 8'h87);
        wait_ev(0, n);
        `CHK("pwm high", 1'b1, pin)
        wr(8'hFB, 8'h85);
        @(negedge clk_sys);
        `CHK("pwm hold", 1'b1, pin)
        wait_ev(0, n);
        `CHK("pwm low", 1'b0, pin)
        wr(8'hFB, 8'h80);
        wait_ev(0, n);
        `CHK("output off", 1'b1, pin)
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            q = $random(seed);
            a0_sel  <= 1'b1;
            top_sel <= 1'b1;
            ext_a0  <= q[0];
            nmi     <= q[1];
            cnt_in  <= q[2];
            repeat (6) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK("a0 pin", q[0], a0_req)
            `CHK("top pin", q[1], top_req)
        end
        @(posedge clk_sys);
        top_sel <= 1'b0;
        @(posedge clk_sys);
        wait_ev(1, n);
        wait_ev(1, n);
        `CHK("top timer", period(8'h0F, 8'h01), n)
        @(posedge clk_sys);
        a0_sel <= 1'b0;
        wait_ev(0, n);
        wait_ev(0, n);
        `CHK("top silent", 1'b0, top_req)
        wr(8'hFB, 8'h00);
        cnt_in <= 1'b1;
        wr(8'hF9, 8'h03);
        wr(8'hFA, 8'h00);
        wr(8'hFB, 8'h89);
        a0_seen = 0;
        for (int i = 0; i < 4; i++) begin
            `CHK("event count", 0, a0_seen)
            repeat (8) @(posedge clk_sys);
            cnt_in <= 1'b0;
            repeat (8) @(posedge clk_sys);
            cnt_in <= 1'b1;
        end
        repeat (4) @(posedge clk_sys);
        `CHK("event end", 1, a0_seen)
        wr(8'hFB, 8'h00);
        wr(8'hF9, 8'h0F);
        wr(8'hFA, 8'h00);
        wr(8'hFC, 8'h3F);
        a0_seen = 0;
        wr(8'hFC, 8'h7F);
        rd(8'hFC, v);
        `CHK("enable stuck", 1'b0, v[6])
        repeat (4) begin
            repeat (30) @(posedge clk_sys);
            refresh;
        end
        wr(8'hF9, 8'h00);
        refresh;
        t0 = cyc;
        wr(8'hF9, 8'hAA);
        wr(8'hF9, 8'h12);
        repeat (20) @(posedge clk_sys);
        wr(8'hF9, 8'h55);
        wait_ev(2, n);
        n = cyc - t0;
        `CHK("watchdog span", 1'b1, n > 56 && n < 72)
        `CHK("no route", 0, a0_seen)
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("reset flag", 1'b1, wd_flag)
        rd(8'hFC, v);
        `CHK("enable restored", 8'h7F, v)
        ext_reset(1'b0);
        `CHK("flag cleared", 1'b0, wd_flag)
        wr(8'hFA, 8'h00);
        repeat (100) @(posedge clk_sys);
        rd(8'hF8, v);
        `CHK("hw count hi", 8'hFF, v)
        rd(8'hF9, v);
        `CHK("hw running", 1'b1, v < 8'hFF)
        ext_reset(1'b1);
        stop_test;
    end

    // Hang guard
    initial begin
        #100us;
        mismatches++;
        stop_test;
    end
endmodule // tb
